// ===== verilog/hcl_hub_launch.sv
// hub side: system counter, identity query and core launch
// assumes requests come from core logic on the same clock
`timescale 1ns/1ps
module hcl_hub_launch import hcl_pkg::*; (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // hub request and answer
    input hcl_req_t req_in,
    output logic req_ready_out,
    output hcl_ans_t ans_out,
    // operand reads
    input wire logic [8:0] src_addr_in,
    input wire logic [31:0] shadow_src_in,
    input wire logic [31:0] shadow_dst_in,
    output logic [31:0] src_operand_out,
    output logic [31:0] dst_operand_out,
    output logic [31:0] sys_count_out,
    // core state
    input wire logic [CORE_COUNT-1:0] core_stop_in,
    output logic [CORE_COUNT-1:0] core_active_out,
    // target core fill
    output hcl_fill_t fill_out,
    output logic spr_clear_out,
    output logic [15:0] boot_par_out,
    output logic core_run_out
);
    typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_EXEC} hcl_hub_state_t;

    hcl_hub_state_t state, next_state;
    hcl_req_t cmd, next_cmd;
    hcl_ans_t next_ans;
    logic [31:0] next_count, next_src_op, next_dst_op;
    logic [2:0] slot, next_slot, exec_count, next_exec_count;
    logic phase, next_phase;
    logic [CORE_COUNT-1:0] next_active;
    logic is_identity, is_launch, window_open, finish;
    logic free_found, ld_busy, ld_start;
    logic [2:0] free_core, launch_core;

    // lowest inactive core, if any
    always_comb begin
        free_found = 1'b0;
        free_core = NO_FREE_CORE;
        for (int i = CORE_COUNT - 1; i >= 0; i--) begin
            if (!core_active_out[i]) begin
                free_found = 1'b1;
                free_core = 3'(i);
            end
        end
    end

    // decode of the captured hub instruction
    assign is_identity = (cmd.opcode == HUB_OPCODE) && (cmd.src == SRC_IDENTITY);
    assign is_launch = (cmd.opcode == HUB_OPCODE) && (cmd.src == SRC_LAUNCH);
    assign window_open = (slot == cmd.core) && !phase;
    // a launch cannot finish while the loader still fills the previous core
    assign finish = (state == HB_EXEC) && (exec_count == EXEC_LAST) && !(is_launch && ld_busy);
    assign launch_core = cmd.dest[LW_NEW_BIT] ? free_core : cmd.dest[LW_CORE_HI:0];
    assign ld_start = finish && is_launch && (free_found || !cmd.dest[LW_NEW_BIT]);
    assign req_ready_out = (state == HB_IDLE);

    // counter, window rotation and operand reads
    always_comb begin
        next_count = sys_count_out + 32'h0000_0001; // wraps without notice
        next_phase = phase + 1'b1;
        next_slot = phase ? slot + 3'h1 : slot;
        // counter address reads the live count, everything else the shadow
        next_src_op = (src_addr_in == COUNTER_REG_ADDR) ? sys_count_out : shadow_src_in;
        next_dst_op = shadow_dst_in; // destination never sees the counter
    end

    // hub operation sequence
    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_exec_count = exec_count;
        next_ans = ans_out;
        next_ans.done = 1'b0;
        next_active = core_active_out & ~core_stop_in;
        case (state)
            HB_IDLE: begin
                if (req_in.valid) begin
                    next_cmd = req_in;
                    next_state = HB_WAIT;
                end
            end
            HB_WAIT: begin
                if (window_open) begin // at most 16 cycles to the window
                    next_state = HB_EXEC;
                    next_exec_count = 3'h0;
                end
            end
            HB_EXEC: begin
                if (exec_count != EXEC_LAST) begin
                    next_exec_count = exec_count + 3'h1;
                end else if (finish) begin
                    next_state = HB_IDLE;
                    next_ans = '0;
                    next_ans.done = 1'b1;
                    if (is_identity) begin
                        next_ans.value = {29'h0000_0000, cmd.core};
                        next_ans.wr_en = !cmd.suppress_result_effect;
                        next_ans.z_en = cmd.update_zero_flag_effect;
                        next_ans.z = (cmd.core == 3'h0);
                        next_ans.c_en = cmd.update_carry_flag_effect;
                        next_ans.c = 1'b0;
                    end else if (is_launch) begin
                        next_ans.value = {29'h0000_0000, launch_core};
                        next_ans.wr_en = cmd.write_result_effect;
                        next_ans.z_en = cmd.update_zero_flag_effect;
                        next_ans.z = (launch_core == 3'h0);
                        next_ans.c_en = cmd.update_carry_flag_effect;
                        next_ans.c = cmd.dest[LW_NEW_BIT] && !free_found;
                        if (ld_start) begin
                            next_active[launch_core] = 1'b1; // restart keeps it active
                        end
                    end
                end
            end
            default: next_state = HB_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sys_count_out <= COUNTER_RESET;
            phase <= 1'b0;
            slot <= 3'h0;
            src_operand_out <= 32'h0000_0000;
            dst_operand_out <= 32'h0000_0000;
        end else if (ce_in) begin
            sys_count_out <= next_count;
            phase <= next_phase;
            slot <= next_slot;
            src_operand_out <= next_src_op;
            dst_operand_out <= next_dst_op;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= HB_IDLE;
            cmd <= '0;
            exec_count <= 3'h0;
            ans_out <= '0;
            core_active_out <= '0;
        end else if (ce_in) begin
            state <= next_state;
            cmd <= next_cmd;
            exec_count <= next_exec_count;
            ans_out <= next_ans;
            core_active_out <= next_active;
        end
    end

    // register fill starts at the edge that gives the answer; the core runs on the shared system clock
    hcl_core_loader u_loader (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .start_in(ld_start),
        .core_in(launch_core),
        .code_addr_in(cmd.dest[LW_CODE_HI:LW_CODE_LO]),
        .par_field_in(cmd.dest[LW_PAR_HI:LW_PAR_LO]),
        .busy_out(ld_busy),
        .fill_out(fill_out),
        .spr_clear_out(spr_clear_out),
        .boot_par_out(boot_par_out),
        .core_run_out(core_run_out)
    );

    // helper: enabled cycles since the request was taken, and loader stalls
    logic [5:0] lat_count;
    logic stalled;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            lat_count <= 6'h00;
            stalled <= 1'b0;
        end else if (ce_in) begin
            if (state == HB_IDLE) begin
                lat_count <= 6'h00;
                stalled <= 1'b0;
            end else begin
                lat_count <= lat_count + 6'h01;
                if (state == HB_EXEC && exec_count == EXEC_LAST && !finish) begin
                    stalled <= 1'b1;
                end
            end
        end
    end

    property p_count_step;
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in |=> sys_count_out == $past(sys_count_out) + 32'h0000_0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step");

    property p_count_freeze;
        @(posedge clk_sys_in) disable iff (rst_in)
        !ce_in |=> $stable(sys_count_out);
    endproperty
    a_count_freeze: assert property (p_count_freeze) else $error("counter moved while frozen");

    // the operand is loaded at the edge that sees the address, with the count of that edge
    property p_src_live;
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && src_addr_in == COUNTER_REG_ADDR |=> src_operand_out == $past(sys_count_out);
    endproperty
    a_src_live: assert property (p_src_live) else $error("counter operand not live");

    property p_dst_shadow;
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in |=> dst_operand_out == $past(shadow_dst_in);
    endproperty
    a_dst_shadow: assert property (p_dst_shadow) else $error("destination not shadow");

    property p_latency;
        @(posedge clk_sys_in) disable iff (rst_in)
        ans_out.done |-> lat_count >= 6'h07 && (lat_count <= 6'h16 || stalled);
    endproperty
    a_latency: assert property (p_latency) else $error("hub latency out of range");

    property p_identity;
        @(posedge clk_sys_in) disable iff (rst_in)
        ans_out.done && is_identity
        |-> ans_out.value == {29'h0000_0000, cmd.core} && ans_out.wr_en == !cmd.suppress_result_effect
            && !ans_out.c && ans_out.z == (cmd.core == 3'h0);
    endproperty
    a_identity: assert property (p_identity) else $error("identity answer wrong");

    property p_launch_flags;
        @(posedge clk_sys_in) disable iff (rst_in)
        ans_out.done && is_launch
        |-> ans_out.z == (ans_out.value == 32'h0000_0000) && ans_out.wr_en == cmd.write_result_effect
            && (!ans_out.c || ans_out.value == 32'h0000_0007);
    endproperty
    a_launch_flags: assert property (p_launch_flags) else $error("launch answer wrong");

    property p_named_start;
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && ld_start && !cmd.dest[LW_NEW_BIT]
        |=> fill_out.valid && fill_out.core == $past(cmd.dest[LW_CORE_HI:0]) && core_active_out[fill_out.core];
    endproperty
    a_named_start: assert property (p_named_start) else $error("named core not started");

    property p_new_start;
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && ld_start && cmd.dest[LW_NEW_BIT] |-> !core_active_out[launch_core] && free_found;
    endproperty
    a_new_start: assert property (p_new_start) else $error("new launch took busy core");
endmodule : hcl_hub_launch

// ===== verilog/hcl_pkg.sv
// package for the hub core launch and system counter block
// assumes one system clock; cores reach the hub through a rotating window
package hcl_pkg;
    localparam int CORE_COUNT = 8;
    localparam int CLK_PERIOD_NS = 50;
    // hub instruction decode
    localparam logic [5:0] HUB_OPCODE = 6'h03;
    localparam logic [8:0] SRC_IDENTITY = 9'h001;
    localparam logic [8:0] SRC_LAUNCH = 9'h002;
    // register addresses inside a core
    localparam logic [8:0] COUNTER_REG_ADDR = 9'h1F1;
    localparam logic [8:0] LAST_LOADED_REG = 9'h1EF;
    // launch word field positions
    localparam int LW_PAR_HI = 31;
    localparam int LW_PAR_LO = 18;
    localparam int LW_CODE_HI = 17;
    localparam int LW_CODE_LO = 4;
    localparam int LW_NEW_BIT = 3;
    localparam int LW_CORE_HI = 2;
    // hub timing, in clock cycles
    localparam int HUB_MIN_CYC = 7;
    localparam int HUB_MAX_CYC = 22;
    localparam int HUB_SLOT_CYC = 2;
    localparam logic [2:0] EXEC_LAST = 3'(HUB_MIN_CYC - 2);
    localparam logic [2:0] NO_FREE_CORE = 3'h7;
    localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic [5:0] opcode;
        logic [8:0] src;
        logic [31:0] dest;
        logic update_zero_flag_effect;
        logic update_carry_flag_effect;
        logic write_result_effect;
        logic suppress_result_effect;
        logic [2:0] core;
    } hcl_req_t;

    typedef struct packed {
        logic done;
        logic wr_en;
        logic z_en;
        logic z;
        logic c_en;
        logic c;
        logic [31:0] value;
    } hcl_ans_t;

    typedef struct packed {
        logic valid;
        logic [2:0] core;
        logic [8:0] reg_addr;
        logic [13:0] hub_long_addr;
    } hcl_fill_t;
endpackage : hcl_pkg

// ===== verilog/hcl_core_loader.sv
// sequencer that fills a started core's registers and lets it run
// assumes main memory answers each fill address outside this block
`timescale 1ns/1ps
module hcl_core_loader import hcl_pkg::*; (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // launch command
    input wire logic start_in,
    input wire logic [2:0] core_in,
    input wire logic [13:0] code_addr_in,
    input wire logic [13:0] par_field_in,
    output logic busy_out,
    // target core side
    output hcl_fill_t fill_out,
    output logic spr_clear_out,
    output logic [15:0] boot_par_out,
    output logic core_run_out
);
    typedef enum logic [1:0] {LD_IDLE, LD_FILL, LD_CLEAR, LD_RUN} hcl_ld_state_t;
    hcl_ld_state_t state, next_state;
    hcl_fill_t next_fill;
    logic next_spr_clear, next_run;
    logic [15:0] next_boot_par;

    // one register per cycle from the code address upward, then clear and go
    always_comb begin
        next_state = state;
        next_fill = fill_out;
        next_fill.valid = 1'b0;
        next_spr_clear = 1'b0;
        next_run = 1'b0;
        next_boot_par = boot_par_out;
        case (state)
            LD_IDLE: begin
                if (start_in) begin
                    next_state = LD_FILL;
                    next_fill.valid = 1'b1;
                    next_fill.core = core_in;
                    next_fill.reg_addr = 9'h000;
                    next_fill.hub_long_addr = code_addr_in;
                    next_boot_par = {par_field_in, 2'b00};
                end
            end
            LD_FILL: begin
                if (fill_out.reg_addr == LAST_LOADED_REG) begin
                    next_state = LD_CLEAR;
                    next_spr_clear = 1'b1;
                end else begin
                    next_fill.valid = 1'b1;
                    next_fill.reg_addr = fill_out.reg_addr + 9'h001;
                    next_fill.hub_long_addr = fill_out.hub_long_addr + 14'h0001;
                end
            end
            LD_CLEAR: begin
                next_state = LD_RUN;
                next_run = 1'b1;
            end
            LD_RUN: next_state = LD_IDLE;
            default: next_state = LD_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            state <= LD_IDLE;
            fill_out <= '0;
            spr_clear_out <= 1'b0;
            core_run_out <= 1'b0;
            boot_par_out <= 16'h0000;
        end else if (ce_in) begin
            state <= next_state;
            fill_out <= next_fill;
            spr_clear_out <= next_spr_clear;
            core_run_out <= next_run;
            boot_par_out <= next_boot_par;
        end
    end

    assign busy_out = (state != LD_IDLE);

    property p_fill_order;
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && fill_out.valid && state == LD_FILL && fill_out.reg_addr != LAST_LOADED_REG
        |=> !ce_in || (fill_out.valid && fill_out.reg_addr == $past(fill_out.reg_addr) + 9'h001);
    endproperty
    a_fill_order: assert property (p_fill_order) else $error("fill order broken");

    property p_boot_par;
        @(posedge clk_sys_in) disable iff (rst_in)
        ce_in && state == LD_IDLE && start_in |=> boot_par_out == {$past(par_field_in), 2'b00};
    endproperty
    a_boot_par: assert property (p_boot_par) else $error("boot pointer wrong");
endmodule : hcl_core_loader

// ===== testbench/hcl_core_model.sv
// model of a started core: register fill sink and shadow register source
// assumes one fill word per clock on the shared system clock
`timescale 1ns/1ps
module hcl_core_model import hcl_pkg::*; (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // fill side from the hub
    input hcl_fill_t fill_in,
    input wire logic spr_clear_in,
    input wire logic core_run_in,
    // shadow registers
    input wire logic [8:0] src_addr_in,
    output logic [31:0] shadow_src_out,
    output logic [31:0] shadow_dst_out,
    // observations for the bench
    output logic [9:0] words_out,
    output logic [13:0] first_addr_out,
    output logic [8:0] last_reg_out,
    output logic order_err_out,
    output logic ran_out
);
    // shadow data follows the address, so a stale read cannot pass for a fresh one
    assign shadow_src_out = 32'h5a5a_0000 | {23'h00_0000, src_addr_in};
    assign shadow_dst_out = 32'hc3c3_3c3c;

    logic spr_seen; // specials cleared since the current load began

    // count fill words and check their order; register 0 opens a new load
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            words_out <= 10'h000;
            first_addr_out <= 14'h0000;
            last_reg_out <= 9'h000;
            order_err_out <= 1'b0;
            ran_out <= 1'b0;
            spr_seen <= 1'b0;
        end else begin
            if (fill_in.valid) begin
                last_reg_out <= fill_in.reg_addr;
                if (fill_in.reg_addr == 9'h000) begin
                    words_out <= 10'h001;
                    first_addr_out <= fill_in.hub_long_addr;
                    spr_seen <= 1'b0;
                    ran_out <= 1'b0;
                end else begin
                    words_out <= words_out + 10'h001;
                    if (fill_in.reg_addr != last_reg_out + 9'h001 ||
                        fill_in.hub_long_addr != first_addr_out + 14'(fill_in.reg_addr)) begin
                        order_err_out <= 1'b1;
                    end
                end
            end
            // specials may only be cleared once the last register is loaded
            if (spr_clear_in && last_reg_out != LAST_LOADED_REG) begin
                order_err_out <= 1'b1;
            end
            if (spr_clear_in) begin
                spr_seen <= 1'b1;
            end
            // running before the specials are cleared is out of order
            if (core_run_in) begin
                ran_out <= 1'b1;
                if (!spr_seen) begin
                    order_err_out <= 1'b1;
                end
            end
        end
    end
endmodule : hcl_core_model

// ===== testbench/tb_hcl_hub_launch.sv
// self-checking bench for the hub launch, identity and counter block
// assumes the core model answers fills; inputs change at the falling edge
`timescale 1ns/1ps
module tb_hcl_hub_launch import hcl_pkg::*;;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    hcl_req_t req = '0;
    hcl_ans_t ans;
    hcl_fill_t fill;
    logic ready, spr, run, oerr, ran;
    logic [8:0] src_addr = COUNTER_REG_ADDR;
    logic [8:0] lastr;
    logic [31:0] sh_src, sh_dst, src_op, dst_op, sys_count, t0;
    logic [7:0] stop = 8'h00;
    logic [7:0] active;
    logic [15:0] bpar;
    logic [9:0] words;
    logic [13:0] first;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;

    hcl_hub_launch dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
        .req_ready_out(ready), .ans_out(ans), .src_addr_in(src_addr), .shadow_src_in(sh_src),
        .shadow_dst_in(sh_dst), .src_operand_out(src_op), .dst_operand_out(dst_op), .sys_count_out(sys_count),
        .core_stop_in(stop), .core_active_out(active), .fill_out(fill), .spr_clear_out(spr),
        .boot_par_out(bpar), .core_run_out(run));
    hcl_core_model core_model (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .fill_in(fill),
        .spr_clear_in(spr), .core_run_in(run), .src_addr_in(src_addr), .shadow_src_out(sh_src),
        .shadow_dst_out(sh_dst), .words_out(words), .first_addr_out(first), .last_reg_out(lastr),
        .order_err_out(oerr), .ran_out(ran));

    // 20 MHz system clock
    initial begin
        forever #(CLK_PERIOD_NS / 2) clk_sys_in = ~clk_sys_in;
    end

    task end_sim;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one hub request: hold valid until taken, then count edges until done; eff is {zero, carry, write, suppress}
    task hub_op(input logic [5:0] op, input logic [8:0] src, input logic [31:0] dest,
                input logic [2:0] core, input logic [3:0] eff);
        @(negedge clk_sys_in);
        req = '{1'b1, op, src, dest, eff[3], eff[2], eff[1], eff[0], core};
        while (ready !== 1'b1) @(negedge clk_sys_in);
        @(negedge clk_sys_in);
        req.valid = 1'b0;
        n = 0;
        while (ans.done !== 1'b1 && n < 600) begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(32'(n >= HUB_MIN_CYC && n <= HUB_MAX_CYC), 32'h1);
    endtask : hub_op

    // launch, check the answer, then let the load finish before the next request
    task launch(input logic [31:0] dest, input logic [3:0] eff, input logic [2:0] expc, input logic no_free);
        hub_op(HUB_OPCODE, SRC_LAUNCH, dest, 3'h1, eff);
        chk(ans.value, {29'h0000_0000, expc});
        chk(ans.z, expc == 3'h0);
        chk(ans.c, no_free);
        chk(ans.wr_en, eff[1]);
        chk({ans.z_en, ans.c_en}, eff[3:2]);
        if (!no_free) begin
            repeat (4) @(negedge clk_sys_in);
            for (int k = 0; k < 700 && ran !== 1'b1; k++) @(negedge clk_sys_in);
            chk(words, 32'd496);
            chk(first, dest[17:4]);
            chk(lastr, LAST_LOADED_REG);
            chk(oerr, 1'b0);
            chk(ran, 1'b1);
            chk(bpar, {dest[31:18], 2'b00});
            chk(active[expc], 1'b1);
        end
    endtask : launch

    // cut a hang short
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_in = 1'b0;
        @(negedge clk_sys_in);
        t0 = sys_count;
        repeat (5) @(negedge clk_sys_in);
        chk(sys_count - t0, 32'h0000_0005);
        t0 = src_op;
        @(negedge clk_sys_in);
        chk(src_op - t0, 32'h0000_0001);
        src_addr = 9'h010;
        @(negedge clk_sys_in);
        chk(src_op, sh_src);
        chk(dst_op, sh_dst);
        // a frozen clock enable must hold the counter
        ce_in = 1'b0;
        t0 = sys_count;
        repeat (3) @(negedge clk_sys_in);
        chk(sys_count, t0);
        ce_in = 1'b1;
        // identity query from every core, result suppressed on odd ones
        for (int i = 0; i < 8; i++) begin
            hub_op(HUB_OPCODE, SRC_IDENTITY, 32'hffff_ffff, i[2:0], {3'b110, i[0]});
            chk(ans.value, 32'(i));
            chk(ans.wr_en, !i[0]);
            chk(ans.z, i == 0);
            chk(ans.c, 1'b0);
            chk({ans.z_en, ans.c_en}, 2'b11);
        end
        // an unknown opcode is answered with nothing enabled
        hub_op(6'h05, SRC_IDENTITY, 32'h0000_0000, 3'h2, 4'b1110);
        chk({ans.wr_en, ans.z_en, ans.c_en}, 3'h0);
        chk(ans.value, 32'h0000_0000);
        // launch words point at native code only named core 5, then restart without write
        launch({14'h0abc, 14'h0100, 1'b0, 3'h5}, 4'b1110, 3'h5, 1'b0);
        launch({14'h1357, 14'h0300, 1'b0, 3'h5}, 4'b1100, 3'h5, 1'b0);
        // new-core launches fill the lowest free cores, then report no free core
        for (int i = 0; i < 8; i++) begin
            if (i != 5) begin
                launch({14'h0040, 14'h0200, 1'b1, 3'h5}, 4'b1110, i[2:0], 1'b0);
            end
        end
        launch({14'h0040, 14'h0200, 1'b1, 3'h0}, 4'b1110, 3'h7, 1'b1);
        // stopping core 2 makes it the next free one
        @(negedge clk_sys_in);
        stop = 8'h04;
        @(negedge clk_sys_in);
        stop = 8'h00;
        @(negedge clk_sys_in);
        chk(active, 8'hfb);
        launch({14'h0041, 14'h0210, 1'b1, 3'h0}, 4'b1110, 3'h2, 1'b0);
        end_sim();
    end
endmodule : tb_hcl_hub_launch
